// ---- hdl/mprvr_device.sv ----
// Device end: mode register six/three/zero decode and serial readout.
// Assumes commands arrive synchronous to core_clk, tCCD spacing kept.
// How it works
// - Decode select; code 111 silently ignored
// - Controller never programs reserved select codes
// - A12:A10 pick long column delay 4..8
// - A7 training enable, A6 range
// - A5:A0 level, 0.65 percent steps
// - Only fixed eight-beat or chopped bursts
// - Chopped read starts at 000 or 100
// - Page 0 defaults, rewritable, kept until reset
// - Controller spaces page 1-3 reads long
// - Controller entry sequence and delays
// - Mode-three A12:A11 format, serial only
// - Reads redirected to location BA1:BA0
// - Controller sets A12 when on-fly length
// - Chopped burst order from A2, chopped tristates
// - Data follows after CAS latency
// - Controller exit sequence and delays
// - Same bits all lanes, bit 7 first
// - Strobes toggle with data, with preamble
`timescale 1ns/1ps
`default_nettype none
module mprvr_device #(
  parameter int DQ_W = 8,
  parameter int CAS_LAT = 10,
  // Page 0 training defaults, one byte per location
  parameter logic [31:0] PAGE0_INIT = 32'h00ff_55aa,
  // Arbitrary value, vendor page content
  parameter logic [7:0] VENDOR_BYTE = 8'h00
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Link
  mprvr_if.dev link,
  // Decoded configuration
  output logic vref_train_en,
  output logic vref_range,
  output logic [5:0] vref_code,
  output logic [13:0] vref_level_centi,
  output logic [3:0] ccd_long_clk,
  output logic mpr_mode,
  output logic mpr_fmt_ok
);
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Pipeline taps off three early so outputs land exactly at CAS_LAT
  localparam int TAP = CAS_LAT - 3;

  typedef struct packed {
    logic v;
    logic bc4;
    logic hi;
    logic [7:0] data;
  } mprvr_rd_t;

  logic [2:0] mr_sel;
  logic is_mrs;
  logic is_rd;
  logic is_wr;
  logic mr0_wr;
  logic mr3_wr;
  logic mr6_wr;
  logic ccd_ok;
  logic vref_ok;
  logic rd_go;
  logic page0_wr;
  logic [7:0] page2_byte;
  logic [7:0] loc_byte;
  mprvr_rd_t rd_new;
  mprvr_rd_t tap;

  logic [2:0] ccd_code_ff;
  logic train_ff;
  logic range_ff;
  logic [5:0] vcode_ff;
  logic mpr_en_ff;
  logic [1:0] page_ff;
  logic [1:0] fmt_ff;
  logic [1:0] bl_mode_ff;
  logic [7:0] page0_ff [4];
  mprvr_rd_t pipe_ff [CAS_LAT];
  logic [13:0] level_ff;
  logic [3:0] ccd_clk_ff;

  assign mr_sel = {link.bg[0], link.ba};
  assign is_mrs = link.cmd_valid && (link.cmd_kind == mprvr_pkg::CMD_MRS);
  assign is_rd = link.cmd_valid && (link.cmd_kind == mprvr_pkg::CMD_RD);
  assign is_wr = link.cmd_valid && (link.cmd_kind == mprvr_pkg::CMD_WR);
  // Select 111 matches none of these, so it leaves every register alone
  assign mr0_wr = is_mrs && (mr_sel == mprvr_pkg::SEL_MR0);
  assign mr3_wr = is_mrs && (mr_sel == mprvr_pkg::SEL_MR3);
  assign mr6_wr = is_mrs && (mr_sel == mprvr_pkg::SEL_MR6);
  // Reserved codes keep the previous field instead of a bogus value
  assign ccd_ok = link.addr[mprvr_pkg::MR6_CCD_LSB +: 3] <=
                  mprvr_pkg::CCD_MAX_CODE;
  assign vref_ok = link.addr[5:0] <= mprvr_pkg::VREF_MAX_CODE;
  assign page0_wr = is_wr && mpr_en_ff && (page_ff == 2'h0);

  // ----------------------------------------------------------------
  // Location select
  // ----------------------------------------------------------------
  // Page 1 error frame is not tracked and reads as zero
  assign page2_byte = (link.ba == 2'h0) ? {train_ff, range_ff, vcode_ff} :
                      (link.ba == 2'h1) ? {5'h00, ccd_code_ff} :
                      (link.ba == 2'h2) ? {4'h0, fmt_ff, page_ff} :
                      {6'h00, bl_mode_ff};
  assign loc_byte = (page_ff == 2'h0) ? page0_ff[link.ba] :
                    (page_ff == 2'h2) ? page2_byte :
                    (page_ff == 2'h3) ? VENDOR_BYTE : 8'h00;
  // Unsupported formats get no burst at all
  assign mpr_fmt_ok = fmt_ff == mprvr_pkg::FMT_SERIAL;
  assign rd_go = is_rd && mpr_en_ff && mpr_fmt_ok;
  // On-the-fly setting runs as a fixed eight-beat burst here
  assign rd_new.v = rd_go;
  assign rd_new.bc4 = bl_mode_ff == mprvr_pkg::BL_BC4;
  assign rd_new.hi = rd_new.bc4 && link.addr[mprvr_pkg::RD_HI_BIT];
  assign rd_new.data = loc_byte;
  assign tap = pipe_ff[TAP];

  // ----------------------------------------------------------------
  // Mode registers and page 0 storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ccd_code_ff <= 3'h0;
      train_ff <= 1'b0;
      range_ff <= 1'b0;
      vcode_ff <= 6'h00;
    end else if (mr6_wr) begin
      if (ccd_ok) begin
        ccd_code_ff <= link.addr[mprvr_pkg::MR6_CCD_LSB +: 3];
      end
      train_ff <= link.addr[mprvr_pkg::MR6_TRAIN_BIT];
      range_ff <= link.addr[mprvr_pkg::MR6_RANGE_BIT];
      if (vref_ok) begin
        vcode_ff <= link.addr[5:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mpr_en_ff <= 1'b0;
      page_ff <= 2'h0;
      fmt_ff <= 2'h0;
      bl_mode_ff <= 2'h0;
    end else if (mr3_wr) begin
      mpr_en_ff <= link.addr[mprvr_pkg::MR3_EN_BIT];
      page_ff <= link.addr[1:0];
      fmt_ff <= link.addr[mprvr_pkg::MR3_FMT_LSB +: 2];
    end else if (mr0_wr) begin
      bl_mode_ff <= link.addr[1:0];
    end
  end

  // Reset is the re-initialisation that restores the defaults
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst) begin
        page0_ff[i] <= PAGE0_INIT[8*i +: 8];
      end else if (page0_wr && (link.ba == 2'(i))) begin
        page0_ff[i] <= link.addr[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      level_ff <= 14'h0000;
      ccd_clk_ff <= 4'h0;
    end else begin
      level_ff <= mprvr_pkg::vref_level(range_ff, vcode_ff);
      ccd_clk_ff <= mprvr_pkg::ccd_clk(ccd_code_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read latency pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < CAS_LAT; k++) begin
      if (srst) begin
        pipe_ff[k] <= '0;
      end else if (k == 0) begin
        pipe_ff[k] <= rd_new;
      end else begin
        pipe_ff[k] <= pipe_ff[k-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst engine and output stage
  // ----------------------------------------------------------------
  logic act_ff;
  logic [1:0] beat_ff;
  logic [7:0] byte_ff;
  logic bc4_ff;
  logic hi_ff;
  logic drive;
  logic nxt_pre;
  logic [2:0] ui_a;
  logic [2:0] ui_b;
  logic [DQ_W-1:0] dq_first_ff;
  logic [DQ_W-1:0] dq_second_ff;
  logic dq_oe_n_ff;
  logic dqs_first_ff;
  logic dqs_oe_n_ff;

  // A read landing early truncates the running burst
  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_ff <= 1'b0;
      beat_ff <= 2'h0;
      byte_ff <= 8'h00;
      bc4_ff <= 1'b0;
      hi_ff <= 1'b0;
    end else if (tap.v) begin
      act_ff <= 1'b1;
      beat_ff <= 2'h0;
      byte_ff <= tap.data;
      bc4_ff <= tap.bc4;
      hi_ff <= tap.hi;
    end else if (act_ff) begin
      beat_ff <= beat_ff + 2'h1;
      act_ff <= beat_ff != 2'h3;
    end
  end

  // Chopped bursts leave the last two clocks tristated
  assign drive = act_ff && !(bc4_ff && beat_ff[1]);
  assign ui_a = {hi_ff | beat_ff[1], beat_ff[0], 1'b0};
  assign ui_b = ui_a | 3'h1;
  // Seamless bursts need no fresh preamble
  assign nxt_pre = tap.v && !drive;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dq_first_ff <= '0;
      dq_second_ff <= '0;
      dq_oe_n_ff <= 1'b1;
      dqs_first_ff <= 1'b0;
      dqs_oe_n_ff <= 1'b1;
    end else begin
      dq_first_ff <= {DQ_W{drive & byte_ff[3'h7 - ui_a]}};
      dq_second_ff <= {DQ_W{drive & byte_ff[3'h7 - ui_b]}};
      dq_oe_n_ff <= !drive;
      dqs_first_ff <= drive;
      dqs_oe_n_ff <= !(drive || nxt_pre);
    end
  end

  assign link.dq_first = dq_first_ff;
  assign link.dq_second = dq_second_ff;
  assign link.dq_oe_n = dq_oe_n_ff;
  assign link.dqs_first = dqs_first_ff;
  assign link.dqs_second = 1'b0;
  assign link.dqs_oe_n = dqs_oe_n_ff;
  assign vref_train_en = train_ff;
  assign vref_range = range_ff;
  assign vref_code = vcode_ff;
  assign vref_level_centi = level_ff;
  assign ccd_long_clk = ccd_clk_ff;
  assign mpr_mode = mpr_en_ff;
endmodule
`default_nettype wire

// ---- hdl/mprvr_pkg.sv ----
// Shared constants and types for the multipurpose-register readout block.
// Assumes both ends run on one command clock.
package mprvr_pkg;
  // ----------------------------------------------------------------
  // Command kinds and mode register selects
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP = 2'b00,
    CMD_MRS = 2'b01,
    CMD_RD = 2'b10,
    CMD_WR = 2'b11
  } mprvr_cmd_t;
  localparam logic [2:0] SEL_MR0 = 3'h0;
  localparam logic [2:0] SEL_MR3 = 3'h3;
  localparam logic [2:0] SEL_MR6 = 3'h6;
  localparam logic [2:0] SEL_RCW = 3'h7;
  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int MR6_CCD_LSB = 10;
  localparam int MR6_TRAIN_BIT = 7;
  localparam int MR6_RANGE_BIT = 6;
  localparam int MR3_EN_BIT = 2;
  localparam int MR3_FMT_LSB = 11;
  localparam int RD_BC_BIT = 12;
  localparam int RD_HI_BIT = 2;
  localparam logic [2:0] CCD_MAX_CODE = 3'h4;
  localparam logic [5:0] VREF_MAX_CODE = 6'h32;
  localparam logic [1:0] FMT_SERIAL = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  // Reference level in hundredths of a percent
  localparam logic [13:0] VREF_R1_BASE = 14'h1770;
  localparam logic [13:0] VREF_R2_BASE = 14'h1194;
  localparam logic [13:0] VREF_STEP = 14'h0041;
  localparam logic [3:0] CCD_BASE_CLK = 4'h4;
  localparam logic [3:0] CCD_S_CLK = 4'h4;
  localparam logic [3:0] BURST_CLK = 4'h4;
  // ----------------------------------------------------------------
  // Controller register map and command word layout
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam int CW_BA_LSB = 14;
  localparam int CW_BG_LSB = 16;
  localparam int CW_KIND_LSB = 18;
  localparam int ST_ERR_BIT = 2;

  function automatic logic [3:0] ccd_clk(input logic [2:0] code);
    ccd_clk = CCD_BASE_CLK + {1'b0, code};
  endfunction

  function automatic logic [13:0] vref_level(input logic rng,
                                             input logic [5:0] code);
    vref_level = (rng ? VREF_R2_BASE : VREF_R1_BASE) +
                 14'(VREF_STEP * {8'h00, code});
  endfunction
endpackage

// ---- hdl/mprvr_if.sv ----
// Command/address and read-data link between controller and device.
// Assumes one clock; two UIs of data per clock, first and second half.
`timescale 1ns/1ps
`default_nettype none
interface mprvr_if #(parameter int DQ_W = 8);
  logic cmd_valid;
  mprvr_pkg::mprvr_cmd_t cmd_kind;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [13:0] addr;
  logic [DQ_W-1:0] dq_first;
  logic [DQ_W-1:0] dq_second;
  logic dq_oe_n;
  logic dqs_first;
  logic dqs_second;
  logic dqs_oe_n;
  modport dev(input cmd_valid, cmd_kind, bg, ba, addr,
              output dq_first, dq_second, dq_oe_n,
              output dqs_first, dqs_second, dqs_oe_n);
  modport ctl(output cmd_valid, cmd_kind, bg, ba, addr,
              input dq_first, dq_second, dq_oe_n,
              input dqs_first, dqs_second, dqs_oe_n);
endinterface
`default_nettype wire

// ---- hdl/mprvr_ctrl.sv ----
// Controller end: takes command words from software, sanitises them,
// spaces them on the link and captures lane 0 of each readout.
// Assumes software waits on the busy bit; precharge and lock are its job.
`timescale 1ns/1ps
`default_nettype none
module mprvr_ctrl #(
  parameter int CAS_LAT = 10,
  parameter logic [7:0] MOD_CLK = 8'h18,
  parameter logic [7:0] MPRR_CLK = 8'h04
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link
  mprvr_if.ctl link
);
  // ----------------------------------------------------------------
  // Command word checks
  // ----------------------------------------------------------------
  mprvr_pkg::mprvr_cmd_t w_kind;
  logic [1:0] w_bg;
  logic [1:0] w_ba;
  logic [13:0] w_addr;
  logic [2:0] w_sel;
  logic w_cmd;
  logic bad;
  logic accept;
  logic [13:0] rd_addr;
  logic [13:0] s_addr;
  logic [1:0] s_bg;
  logic issue;
  logic [7:0] rd_gap;
  logic [7:0] exit_gap;

  logic pend_ff;
  mprvr_pkg::mprvr_cmd_t kind_ff;
  logic [1:0] bg_ff;
  logic [1:0] ba_ff;
  logic [13:0] addr_ff;
  logic err_ff;
  logic [1:0] bl_sh_ff;
  logic [1:0] page_sh_ff;
  logic [2:0] ccd_sh_ff;
  logic [7:0] gap_ff;
  logic [7:0] mrs_gap_ff;
  logic v_ff;
  mprvr_pkg::mprvr_cmd_t k_ff;
  logic [1:0] lbg_ff;
  logic [1:0] lba_ff;
  logic [13:0] la_ff;

  assign w_kind =
    mprvr_pkg::mprvr_cmd_t'(reg_wdata[mprvr_pkg::CW_KIND_LSB +: 2]);
  assign w_bg = reg_wdata[mprvr_pkg::CW_BG_LSB +: 2];
  assign w_ba = reg_wdata[mprvr_pkg::CW_BA_LSB +: 2];
  assign w_addr = reg_wdata[13:0];
  assign w_sel = {w_bg[0], w_ba};
  assign w_cmd = reg_wr && (reg_addr == mprvr_pkg::REG_CMD);
  assign bad = pend_ff ||
    ((w_kind == mprvr_pkg::CMD_MRS) &&
     (w_sel == mprvr_pkg::SEL_RCW)) ||
    ((w_kind == mprvr_pkg::CMD_MRS) && (w_sel == mprvr_pkg::SEL_MR6) &&
     ((w_addr[mprvr_pkg::MR6_CCD_LSB +: 3] > mprvr_pkg::CCD_MAX_CODE) ||
      (w_addr[5:0] > mprvr_pkg::VREF_MAX_CODE)));
  assign accept = w_cmd && !bad && (w_kind != mprvr_pkg::CMD_NOP);
  // Reads: nibble start 00, A2 only for chopped, A12 for on-fly length
  assign rd_addr = {w_addr[13],
                    w_addr[12] | (bl_sh_ff == mprvr_pkg::BL_OTF),
                    w_addr[11:3],
                    w_addr[2] & (bl_sh_ff == mprvr_pkg::BL_BC4),
                    2'h0};
  assign s_addr = (w_kind == mprvr_pkg::CMD_RD) ? rd_addr :
                  ((w_kind == mprvr_pkg::CMD_MRS) &&
                   (w_sel == mprvr_pkg::SEL_MR6)) ?
                  (w_addr & 14'h1cff) : w_addr;
  assign s_bg = ((w_kind == mprvr_pkg::CMD_MRS) &&
                 (w_sel == mprvr_pkg::SEL_MR6)) ? {1'b0, w_bg[0]} : w_bg;
  // Pages 1-3 must wait the long delay
  assign rd_gap = (page_sh_ff == 2'h0) ? {4'h0, mprvr_pkg::CCD_S_CLK} :
                  {4'h0, mprvr_pkg::ccd_clk(ccd_sh_ff)};
  assign exit_gap = 8'(CAS_LAT) + {4'h0, mprvr_pkg::BURST_CLK} +
                    MPRR_CLK;
  assign issue = pend_ff && (gap_ff == 8'h00) &&
                 ((kind_ff != mprvr_pkg::CMD_MRS) || (mrs_gap_ff == 8'h00));

  // ----------------------------------------------------------------
  // Pending slot, spacing and shadows
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
      kind_ff <= mprvr_pkg::CMD_NOP;
      bg_ff <= 2'h0;
      ba_ff <= 2'h0;
      addr_ff <= 14'h0000;
    end else if (accept) begin
      pend_ff <= 1'b1;
      kind_ff <= w_kind;
      bg_ff <= s_bg;
      ba_ff <= w_ba;
      addr_ff <= s_addr;
    end else if (issue) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gap_ff <= 8'h00;
      mrs_gap_ff <= 8'h00;
    end else if (issue && (kind_ff == mprvr_pkg::CMD_MRS)) begin
      gap_ff <= MOD_CLK - 8'h01;
      mrs_gap_ff <= MOD_CLK - 8'h01;
    end else if (issue && (kind_ff == mprvr_pkg::CMD_RD)) begin
      gap_ff <= rd_gap - 8'h01;
      mrs_gap_ff <= exit_gap - 8'h01;
    end else begin
      gap_ff <= (gap_ff == 8'h00) ? 8'h00 : gap_ff - 8'h01;
      mrs_gap_ff <= (mrs_gap_ff == 8'h00) ? 8'h00 : mrs_gap_ff - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bl_sh_ff <= 2'h0;
      page_sh_ff <= 2'h0;
      ccd_sh_ff <= 3'h0;
    end else if (issue && (kind_ff == mprvr_pkg::CMD_MRS)) begin
      if ({bg_ff[0], ba_ff} == mprvr_pkg::SEL_MR0) begin
        bl_sh_ff <= addr_ff[1:0];
      end
      if ({bg_ff[0], ba_ff} == mprvr_pkg::SEL_MR3) begin
        page_sh_ff <= addr_ff[1:0];
      end
      if ({bg_ff[0], ba_ff} == mprvr_pkg::SEL_MR6) begin
        ccd_sh_ff <= addr_ff[mprvr_pkg::MR6_CCD_LSB +: 3];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      v_ff <= 1'b0;
      k_ff <= mprvr_pkg::CMD_NOP;
      lbg_ff <= 2'h0;
      lba_ff <= 2'h0;
      la_ff <= 14'h0000;
    end else begin
      v_ff <= issue;
      k_ff <= issue ? kind_ff : mprvr_pkg::CMD_NOP;
      lbg_ff <= bg_ff;
      lba_ff <= ba_ff;
      la_ff <= addr_ff;
    end
  end

  // ----------------------------------------------------------------
  // Readout capture and register port
  // ----------------------------------------------------------------
  logic [7:0] sh_ff;
  logic [1:0] cnt_ff;
  logic [7:0] data_ff;
  logic valid_ff;
  logic [31:0] rdata_ff;
  logic latch;
  logic data_rd;
  logic err_clr;
  logic [31:0] rsel;

  // Eight-beat bursts close on the fourth clock, chopped on data release
  assign latch = (!link.dq_oe_n && (cnt_ff == 2'h3)) ||
                 (link.dq_oe_n && (cnt_ff != 2'h0));
  assign data_rd = reg_rd && (reg_addr == mprvr_pkg::REG_DATA);
  assign err_clr = reg_wr && (reg_addr == mprvr_pkg::REG_STAT) &&
                   reg_wdata[mprvr_pkg::ST_ERR_BIT];
  assign rsel = (reg_addr == mprvr_pkg::REG_STAT) ?
                {29'h0, err_ff, valid_ff, pend_ff} :
                (reg_addr == mprvr_pkg::REG_DATA) ? {24'h0, data_ff} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sh_ff <= 8'h00;
      cnt_ff <= 2'h0;
      data_ff <= 8'h00;
      valid_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      if (!link.dq_oe_n) begin
        sh_ff <= latch ? 8'h00 : {sh_ff[5:0], link.dq_first[0],
                                  link.dq_second[0]};
        cnt_ff <= cnt_ff + 2'h1;
      end else begin
        cnt_ff <= 2'h0;
        sh_ff <= 8'h00;
      end
      if (latch) begin
        data_ff <= link.dq_oe_n ? sh_ff :
                   {sh_ff[5:0], link.dq_first[0], link.dq_second[0]};
      end
      // A capture in the same cycle as the clearing read wins
      valid_ff <= latch || (valid_ff && !data_rd);
      err_ff <= (w_cmd && bad) || (err_ff && !err_clr);
      rdata_ff <= reg_rd ? rsel : 32'h0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign link.cmd_valid = v_ff;
  assign link.cmd_kind = k_ff;
  assign link.bg = lbg_ff;
  assign link.ba = lba_ff;
  assign link.addr = la_ff;
endmodule
`default_nettype wire

// ---- verification/mprvr_props.sv ----
// Link checker for the readout block, on interface signals only.
// Assumes CAS_LAT matches both ends and the controller keeps spacing.
`timescale 1ns/1ps
`default_nettype none
module mprvr_props #(
  parameter int DQ_W = 8,
  parameter int CAS_LAT = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Command lines
  input wire logic cmd_valid,
  input wire mprvr_pkg::mprvr_cmd_t cmd_kind,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [13:0] addr,
  // Data and strobe lines
  input wire logic [DQ_W-1:0] dq_first,
  input wire logic [DQ_W-1:0] dq_second,
  input wire logic dq_oe_n,
  input wire logic dqs_first,
  input wire logic dqs_second,
  input wire logic dqs_oe_n
);
  // ----
  // Mode tracking, mirrors what the device latched
  // ----
  localparam int CL_M1 = CAS_LAT - 1;
  logic live_ff;
  logic bc4_ff;
  wire logic [2:0] sel = {bg[0], ba};
  wire logic is_mrs = cmd_valid && cmd_kind == mprvr_pkg::CMD_MRS;
  wire logic is_rd = cmd_valid && cmd_kind == mprvr_pkg::CMD_RD;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      live_ff <= 1'b0;
    end else if (is_mrs && sel == mprvr_pkg::SEL_MR3) begin
      live_ff <= addr[2] && addr[12:11] == mprvr_pkg::FMT_SERIAL;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bc4_ff <= 1'b0;
    end else if (is_mrs && sel == mprvr_pkg::SEL_MR0) begin
      bc4_ff <= addr[1:0] == mprvr_pkg::BL_BC4;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rd_live; is_rd && live_ff; endsequence
  sequence s_rd_bl8; is_rd && live_ff && !bc4_ff; endsequence
  sequence s_rd_bc4; is_rd && live_ff && bc4_ff; endsequence
  a_strobe_lead: assert property (s_rd_live |-> ##CL_M1 !dqs_oe_n)
    else $error("strobe not driven ahead of read data");
  a_full_burst: assert property (
    s_rd_bl8 |-> ##CAS_LAT (!dq_oe_n)[*4])
    else $error("eight-beat read data missing after latency");
  a_chop_release: assert property (
    s_rd_bc4 |-> ##CAS_LAT (!dq_oe_n)[*2] ##1 dq_oe_n)
    else $error("chopped read not two data clocks then released");
  a_rd_off_quiet: assert property (
    is_rd && !live_ff |-> ##CAS_LAT dq_oe_n)
    else $error("data driven for a read outside readout mode");
  a_lanes_equal: assert property (
    !dq_oe_n |-> dq_first == {DQ_W{dq_first[0]}} &&
    dq_second == {DQ_W{dq_second[0]}})
    else $error("data lanes differ during readout");
  a_strobe_with_data: assert property (
    !dq_oe_n |-> !dqs_oe_n && dqs_first)
    else $error("strobe not toggling with data");
  a_second_half_low: assert property (!dqs_oe_n |-> !dqs_second)
    else $error("strobe second half not low");
  a_preamble_shape: assert property (
    $fell(dqs_oe_n) |-> !dqs_first && dq_oe_n ##1 !dq_oe_n)
    else $error("preamble not followed by data");
endmodule
`default_nettype wire

// ---- verification/mpr_readout_and_vref_config_tb.sv ----
// Testbench: controller and device joined by the link interface.
// Assumes software-style polling of the controller busy bit.
`timescale 1ns/1ps
`default_nettype none
module mpr_readout_and_vref_config_tb;
  localparam int CL = 10;
  localparam logic [31:0] P0 = 32'h00ff_55aa;
  logic core_clk;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic tr;
  logic rg;
  logic [5:0] vc;
  logic [13:0] lvl;
  logic [3:0] ccd;
  logic mode;
  logic fmt;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  mprvr_if #(.DQ_W(8)) link ();
  mprvr_device #(.CAS_LAT(CL), .PAGE0_INIT(P0)) mprvr_device_i (
    .core_clk(core_clk), .srst(srst), .link(link), .vref_train_en(tr),
    .vref_range(rg), .vref_code(vc), .vref_level_centi(lvl),
    .ccd_long_clk(ccd), .mpr_mode(mode), .mpr_fmt_ok(fmt));
  mprvr_ctrl #(.CAS_LAT(CL)) mprvr_ctrl_i (.core_clk(core_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
  mprvr_props #(.DQ_W(8), .CAS_LAT(CL)) mprvr_props_i (
    .core_clk(core_clk), .srst(srst), .cmd_valid(link.cmd_valid),
    .cmd_kind(link.cmd_kind), .bg(link.bg), .ba(link.ba), .addr(link.addr),
    .dq_first(link.dq_first), .dq_second(link.dq_second),
    .dq_oe_n(link.dq_oe_n), .dqs_first(link.dqs_first),
    .dqs_second(link.dqs_second), .dqs_oe_n(link.dqs_oe_n));
  // ----
  // Bus tasks and checks
  // ----
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Ceiling is tens of times the expected run, so a hang ends cleanly
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic cmd(input mprvr_pkg::mprvr_cmd_t k, input logic [2:0] sel,
                     input logic [13:0] a);
    logic [31:0] s;
    wr(mprvr_pkg::REG_CMD, {12'h000, k, 1'b0, sel, a});
    for (int i = 0; i < 100; i++) begin
      rd(mprvr_pkg::REG_STAT, s);
      if (s[0] === 1'b0) break;
    end
    repeat (3) @(posedge core_clk);
  endtask
  task automatic mpr_rd(input logic [1:0] loc, input logic a2,
                        input logic [7:0] e, input int hi);
    logic [31:0] s;
    cmd(mprvr_pkg::CMD_RD, {1'b0, loc}, {11'h000, a2, 2'h0});
    for (int i = 0; i < 20 && link.dq_oe_n !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("beat", 32'({link.dq_first[0], link.dq_second[0]}),
        32'({e[hi], e[hi-1]}));
    repeat (5) @(posedge core_clk);
    rd(mprvr_pkg::REG_STAT, s);
    chk("valid set", 32'(s[1]), 32'h1);
    rd(mprvr_pkg::REG_DATA, s);
    chk("byte", s, 32'(e));
    rd(mprvr_pkg::REG_STAT, s);
    chk("valid clr", 32'(s[1]), 32'h0);
  endtask
  task automatic quiet_rd();
    int n;
    n = 0;
    cmd(mprvr_pkg::CMD_RD, 3'h0, 14'h0000);
    repeat (CL + 6) begin
      @(posedge core_clk);
      #1;
      if (link.dq_oe_n !== 1'b1) n++;
    end
    chk("quiet", 32'(n), 32'h0);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_mr6();
    logic [5:0] c;
    logic [31:0] s;
    chk("rst lvl", 32'(lvl), 32'h1770);
    for (int i = 0; i < 5; i++) begin
      c = (i == 4) ? 6'h32 : 6'(i * 12);
      cmd(mprvr_pkg::CMD_MRS, 3'h6, {1'b1, 3'(i), 2'h3, 1'b1, i[0], c});
      chk("ccd", 32'(ccd), 32'(4 + i));
      chk("cfg", 32'({tr, rg, vc}), 32'({1'b1, i[0], c}));
      chk("lvl", 32'(lvl), (i[0] ? 32'h1194 : 32'h1770) + 32'(65 * c));
    end
    cmd(mprvr_pkg::CMD_MRS, 3'h6, 14'h1633);
    rd(mprvr_pkg::REG_STAT, s);
    chk("err", 32'(s[2]), 32'h1);
    chk("ccd kept", 32'(ccd), 32'h8);
    wr(mprvr_pkg::REG_STAT, 32'h4);
    cmd(mprvr_pkg::CMD_MRS, 3'h7, 14'h0000);
    rd(mprvr_pkg::REG_STAT, s);
    chk("sel7", 32'(s[2]), 32'h1);
    wr(mprvr_pkg::REG_STAT, 32'h4);
    $display("done mode register six");
  endtask
  task automatic t_mpr();
    cmd(mprvr_pkg::CMD_MRS, 3'h0, 14'h0000);
    cmd(mprvr_pkg::CMD_MRS, 3'h3, 14'h0004);
    chk("mode", 32'({mode, fmt}), 32'h3);
    for (int k = 0; k < 4; k++) mpr_rd(2'(k), 1'b0, P0[8*k+:8], 7);
    cmd(mprvr_pkg::CMD_MRS, 3'h3, 14'h0006);
    mpr_rd(2'h1, 1'b0, 8'h04, 7);
    mpr_rd(2'h0, 1'b0, 8'hb2, 7);
    cmd(mprvr_pkg::CMD_MRS, 3'h0, 14'h0002);
    mpr_rd(2'h0, 1'b0, 8'h0b, 3);
    mpr_rd(2'h0, 1'b1, 8'h02, 3);
    cmd(mprvr_pkg::CMD_MRS, 3'h3, 14'h1804);
    chk("fmt", 32'({mode, fmt}), 32'h2);
    quiet_rd();
    cmd(mprvr_pkg::CMD_MRS, 3'h3, 14'h0000);
    chk("exit", 32'(mode), 32'h0);
    quiet_rd();
    $display("done readout");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_mr6();
    t_mpr();
    results();
  end
endmodule
`default_nettype wire
